/* tap_defines.vh */
`ifndef TAP_DEFINES_VH
`define TAP_DEFINES_VH
// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define IR_WIDTH        3
`define IR_EXTEST       3'h0
`define IR_IDENT        3'h1
`define IR_SAMPLE_FLOAT 3'h2
`define IR_SAMPLE_PRE   3'h4
`define IR_BYPASS       3'h7
`define IR_CAPTURE_LOW  2'h1
// ----------------------------------------------------------------------
// Register sizes and positions
// ----------------------------------------------------------------------
`define BSR_WIDTH       109
`define BSR_FLOAT_BIT   108
`define ID_WIDTH        32
// Identification code: the value is arbitrary.
`define ID_CODE         32'h0ABC_DEF1
// ----------------------------------------------------------------------
// Controller states
// ----------------------------------------------------------------------
`define ST_RESET        4'h0
`define ST_IDLE         4'h1
`define ST_SEL_DR       4'h2
`define ST_CAP_DR       4'h3
`define ST_SHIFT_DR     4'h4
`define ST_EXIT1_DR     4'h5
`define ST_PAUSE_DR     4'h6
`define ST_EXIT2_DR     4'h7
`define ST_UPD_DR       4'h8
`define ST_SEL_IR       4'h9
`define ST_CAP_IR       4'hA
`define ST_SHIFT_IR     4'hB
`define ST_EXIT1_IR     4'hC
`define ST_PAUSE_IR     4'hD
`define ST_EXIT2_IR     4'hE
`define ST_UPD_IR       4'hF
`endif

/* tap_sync.v */
`timescale 1ns/1ps
// Two-stage synchroniser for the scan pins.
// Reset loads the idle pin levels (data and mode high, scan clock low), so
// that the edge detector sees no false scan clock edge after reset.
module tap_sync (
  input  wire       clk,
  input  wire       rst,
  input  wire [2:0] d,
  output reg  [2:0] q
);
  reg [2:0] meta_reg;
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= 3'h6;
      q        <= 3'h6;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

/* tap_fsm.v */
`timescale 1ns/1ps
`include "tap_defines.vh"
// Sixteen-state controller, advanced once per rising scan clock edge.
module tap_fsm (
  input  wire       clk,
  input  wire       rst,
  input  wire       adv,
  input  wire       tms,
  output reg  [3:0] state_reg
);
  reg [3:0] state_next;
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ST_RESET:    state_next = tms ? `ST_RESET    : `ST_IDLE;
      `ST_IDLE:     state_next = tms ? `ST_SEL_DR   : `ST_IDLE;
      `ST_SEL_DR:   state_next = tms ? `ST_SEL_IR   : `ST_CAP_DR;
      `ST_CAP_DR:   state_next = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
      `ST_SHIFT_DR: state_next = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
      `ST_EXIT1_DR: state_next = tms ? `ST_UPD_DR   : `ST_PAUSE_DR;
      `ST_PAUSE_DR: state_next = tms ? `ST_EXIT2_DR : `ST_PAUSE_DR;
      `ST_EXIT2_DR: state_next = tms ? `ST_UPD_DR   : `ST_SHIFT_DR;
      `ST_UPD_DR:   state_next = tms ? `ST_SEL_DR   : `ST_IDLE;
      `ST_SEL_IR:   state_next = tms ? `ST_RESET    : `ST_CAP_IR;
      `ST_CAP_IR:   state_next = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
      `ST_SHIFT_IR: state_next = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
      `ST_EXIT1_IR: state_next = tms ? `ST_UPD_IR   : `ST_PAUSE_IR;
      `ST_PAUSE_IR: state_next = tms ? `ST_EXIT2_IR : `ST_PAUSE_IR;
      `ST_EXIT2_IR: state_next = tms ? `ST_UPD_IR   : `ST_SHIFT_IR;
      `ST_UPD_IR:   state_next = tms ? `ST_SEL_DR   : `ST_IDLE;
      default:      state_next = `ST_RESET;
    endcase
  end
  always @(posedge clk) begin
    if (rst)
      state_reg <= `ST_RESET;
    else if (adv)
      state_reg <= state_next;
  end
endmodule

/* tap_top.v */
`timescale 1ns/1ps
`include "tap_defines.vh"
module tap_top (
  // System
  input  wire                  REF_CLK,
  input  wire                  SYS_RST,
  // Scan port
  input  wire                  TCK,
  input  wire                  TMS,
  input  wire                  TDI,
  output reg                   TDO,
  output reg                   TDO_OE,
  // Memory pin ring
  input  wire [`BSR_WIDTH-1:0] PIN_RING,
  input  wire                  MEM_OUT_EN,
  output reg  [`BSR_WIDTH-1:0] PIN_DRIVE,
  output reg                   PIN_DRIVE_SEL,
  output reg                   OUT_BUS_EN
);
  // --------------------------------------------------------------------
  // Pin synchronisation and edge detection
  // --------------------------------------------------------------------
  wire [2:0] pins_sync;
  reg        tck_prev_reg;
  wire       tck_rise;
  wire       tck_fall;
  wire       tms_s;
  wire       tdi_s;

  tap_sync u_sync (
    .clk (REF_CLK),
    .rst (SYS_RST),
    .d   ({TDI, TMS, TCK}),
    .q   (pins_sync)
  );

  assign tms_s    = pins_sync[1];
  assign tdi_s    = pins_sync[2];
  assign tck_rise = pins_sync[0] & ~tck_prev_reg;
  assign tck_fall = ~pins_sync[0] & tck_prev_reg;

  always @(posedge REF_CLK) begin
    if (SYS_RST)
      tck_prev_reg <= 1'b0;
    else
      tck_prev_reg <= pins_sync[0];
  end

  // --------------------------------------------------------------------
  // Controller
  // --------------------------------------------------------------------
  wire [3:0] state;

  tap_fsm u_fsm (
    .clk       (REF_CLK),
    .rst       (SYS_RST),
    .adv       (tck_rise),
    .tms       (tms_s),
    .state_reg (state)
  );

  // --------------------------------------------------------------------
  // Instruction decode
  // --------------------------------------------------------------------
  reg [`IR_WIDTH-1:0] ir_shift_reg;
  reg [`IR_WIDTH-1:0] ir_reg;

  // Selects the boundary register for a given instruction.
  function sel_bsr;
    input [`IR_WIDTH-1:0] code;
    begin
      sel_bsr = (code == `IR_EXTEST) || (code == `IR_SAMPLE_FLOAT) ||
                (code == `IR_SAMPLE_PRE);
    end
  endfunction

  wire is_ident = (ir_reg == `IR_IDENT);
  wire is_bsr   = sel_bsr(ir_reg);
  // Anything else, reserved codes included, selects bypass.
  wire is_byp   = ~is_ident & ~is_bsr;

  // --------------------------------------------------------------------
  // Instruction register
  // --------------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ir_shift_reg <= `IR_IDENT;
      ir_reg       <= `IR_IDENT;
    end else if (state == `ST_RESET) begin
      // Test-Logic-Reset acts at once, not at the next scan clock rise.
      ir_reg <= `IR_IDENT;
    end else if (tck_rise) begin
      case (state)
        `ST_CAP_IR: begin
          ir_shift_reg <= {ir_shift_reg[2], `IR_CAPTURE_LOW};
        end
        `ST_SHIFT_IR: begin
          ir_shift_reg <= {tdi_s, ir_shift_reg[2:1]};
        end
        `ST_UPD_IR: begin
          ir_reg <= ir_shift_reg;
        end
        default: begin
          ir_reg <= ir_reg;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Data registers
  // --------------------------------------------------------------------
  reg                  byp_reg;
  reg [`ID_WIDTH-1:0]  id_reg;
  reg [`BSR_WIDTH-1:0] bsr_reg;
  reg [`BSR_WIDTH-1:0] preload_reg;

  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      byp_reg     <= 1'b0;
      id_reg      <= `ID_CODE;
      bsr_reg     <= {`BSR_WIDTH{1'b0}};
      preload_reg <= {`BSR_WIDTH{1'b0}};
    end else if (state == `ST_RESET) begin
      preload_reg[`BSR_FLOAT_BIT] <= 1'b0;
    end else if (tck_rise) begin
      case (state)
        `ST_CAP_DR: begin
          if (is_byp)
            byp_reg <= 1'b0;
          if (is_ident)
            id_reg <= `ID_CODE;
          if (is_bsr)
            bsr_reg <= PIN_RING;
        end
        `ST_SHIFT_DR: begin
          if (is_byp)
            byp_reg <= tdi_s;
          if (is_ident)
            id_reg <= {tdi_s, id_reg[`ID_WIDTH-1:1]};
          if (is_bsr)
            bsr_reg <= {tdi_s, bsr_reg[`BSR_WIDTH-1:1]};
        end
        `ST_UPD_DR: begin
          if (is_bsr)
            preload_reg <= bsr_reg;
        end
        default: begin
          byp_reg <= byp_reg;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Serial output, changed on the falling scan clock edge
  // --------------------------------------------------------------------
  reg tdo_next;
  always @* begin
    if (state == `ST_SHIFT_IR)
      tdo_next = ir_shift_reg[0];
    else if (is_ident)
      tdo_next = id_reg[0];
    else if (is_bsr)
      tdo_next = bsr_reg[0];
    else
      tdo_next = byp_reg;
  end

  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      TDO    <= 1'b0;
      TDO_OE <= 1'b0;
    end else if (tck_fall) begin
      TDO    <= tdo_next;
      TDO_OE <= (state == `ST_SHIFT_DR) || (state == `ST_SHIFT_IR);
    end
  end

  // --------------------------------------------------------------------
  // Pin ring control
  // --------------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PIN_DRIVE     <= {`BSR_WIDTH{1'b0}};
      PIN_DRIVE_SEL <= 1'b0;
      OUT_BUS_EN    <= 1'b0;
    end else begin
      PIN_DRIVE     <= preload_reg;
      PIN_DRIVE_SEL <= (ir_reg == `IR_EXTEST);
      if (ir_reg == `IR_EXTEST)
        OUT_BUS_EN <= preload_reg[`BSR_FLOAT_BIT];
      else if (ir_reg == `IR_SAMPLE_FLOAT)
        OUT_BUS_EN <= 1'b0;
      else
        OUT_BUS_EN <= MEM_OUT_EN;
    end
  end
endmodule

/* tap_top_sva.sv */
`timescale 1ns/1ps
`include "tap_defines.vh"
// ------------------------------------------------------------
// Port checks
// ------------------------------------------------------------
module tap_top_chk (
  input wire                  REF_CLK,
  input wire                  SYS_RST,
  input wire                  TCK,
  input wire                  TMS,
  input wire                  TDI,
  input wire                  TDO,
  input wire                  TDO_OE,
  input wire [`BSR_WIDTH-1:0] PIN_RING,
  input wire                  MEM_OUT_EN,
  input wire [`BSR_WIDTH-1:0] PIN_DRIVE,
  input wire                  PIN_DRIVE_SEL,
  input wire                  OUT_BUS_EN
);
  reg       tck_d_reg;
  reg [2:0] hi_cnt_reg;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // Counts consecutive scan clock rises seen with mode select high, cleared by a rise with it low, saturating at five.
  always @(posedge REF_CLK) begin
    tck_d_reg <= TCK;
    if (SYS_RST)
      hi_cnt_reg <= 3'h0;
    else if (TCK && !tck_d_reg)
      hi_cnt_reg <= TMS ? hi_cnt_reg + {2'h0, hi_cnt_reg != 3'h5} : 3'h0;
  end
  a_tdo_fall: assert property (
    $changed(TDO) |-> !$past(TCK, 2))
    else $error("serial out moved away from a scan clock fall");
  a_oe_fall: assert property (
    $changed(TDO_OE) |-> !$past(TCK, 2))
    else $error("serial out enable moved away from a scan clock fall");
  a_drive_rise: assert property (
    $changed(PIN_DRIVE) |-> $past(TCK, 2))
    else $error("preload stage moved away from a scan clock rise");
  a_sel_rise: assert property (
    $changed(PIN_DRIVE_SEL) |-> $past(TCK, 2))
    else $error("instruction took effect away from a scan clock rise");
  a_float_cell: assert property (
    PIN_DRIVE_SEL && $past(PIN_DRIVE_SEL) && $stable(PIN_DRIVE)
    |-> OUT_BUS_EN == PIN_DRIVE[`BSR_FLOAT_BIT])
    else $error("output bus enable differs from the float cell");
  a_bus_quiet: assert property (
    !PIN_DRIVE_SEL && !$past(PIN_DRIVE_SEL) && OUT_BUS_EN
    |-> $past(MEM_OUT_EN))
    else $error("output bus driven without the memory asking");
  a_five_high: assert property (
    hi_cnt_reg == 3'h5
    |-> ##[0:8] (!PIN_DRIVE_SEL && !PIN_DRIVE[`BSR_FLOAT_BIT]))
    else $error("five high mode bits did not reset the port");
  a_reset_vals: assert property (
    $fell(SYS_RST) |-> !TDO_OE && !PIN_DRIVE_SEL && !(|PIN_DRIVE))
    else $error("outputs not at reset values after reset");
endmodule
bind tap_top tap_top_chk u_chk (.REF_CLK, .SYS_RST, .TCK, .TMS, .TDI, .TDO,
  .TDO_OE, .PIN_RING, .MEM_OUT_EN, .PIN_DRIVE, .PIN_DRIVE_SEL, .OUT_BUS_EN);

/* scan_host.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Board scan controller
// ------------------------------------------------------------
module scan_host (
  // Bench clock, used to keep scan edges clear of its rising edge.
  input  wire  clk,
  // Scan port
  output logic TCK,
  output logic TMS,
  output logic TDI,
  input  wire  TDO
);
  logic b;
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b1;
  end
  // One scan clock period; the clock stands low between frames.
  task automatic step(input logic ms, input logic di, output logic dout);
    TMS = ms;
    TDI = di;
    #40;
    TCK = 1'b1;
    #40;
    dout = TDO;
    TCK = 1'b0;
  endtask
  task automatic tap_reset();
    @(posedge clk) #1;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
  // TDI returns to its pulled-up level outside the shift bits.
  task automatic shift(input logic ir, input int n, input logic [108:0] din,
                       output logic [108:0] dout);
    dout = 109'h0;
    @(posedge clk) #1;
    step(1'b1, 1'b1, b);
    if (ir)
      step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
endmodule

/* test_tap_top.sv */
`timescale 1ns/1ps
`include "tap_defines.vh"
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); \
  end \
end
module test_tap_top;
  localparam logic [108:0] RING_A = 109'h1_2345_6789_ABCD_EF01_2345_6789;
  localparam logic [108:0] PRE_A  = {1'b1, 108'hC3A5};
  localparam logic [108:0] PRE_B  = {1'b0, 108'h5A};
  logic                  REF_CLK, SYS_RST, MEM_OUT_EN;
  wire                   TCK, TMS, TDI, TDO, TDO_OE, PIN_DRIVE_SEL, OUT_BUS_EN;
  logic [`BSR_WIDTH-1:0] PIN_RING, d;
  wire  [`BSR_WIDTH-1:0] PIN_DRIVE;
  int                    n_fail = 0;
  int                    n_compared = 0;
  int                    cyc = 0;
  tap_top DUT (.REF_CLK, .SYS_RST, .TCK, .TMS, .TDI, .TDO, .TDO_OE, .PIN_RING,
    .MEM_OUT_EN, .PIN_DRIVE, .PIN_DRIVE_SEL, .OUT_BUS_EN);
  scan_host u_host (.clk (REF_CLK), .TCK, .TMS, .TDI, .TDO);
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  task automatic summarize();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic load_ir(input logic [2:0] code);
    u_host.shift(1'b1, 3, {106'h0, code}, d);
    `CHK("ir_capture", 2'h1, d[1:0])
  endtask
  task automatic t_ident();
    u_host.shift(1'b0, 32, 109'h0, d);
    `CHK("id_after_reset", `ID_CODE, d[31:0])
    load_ir(`IR_IDENT);
    u_host.shift(1'b0, 32, 109'h0, d);
    `CHK("id_code", `ID_CODE, d[31:0])
    $display("ident test done");
  endtask
  task automatic t_bypass();
    // Reserved codes are sent on purpose here and nowhere else.
    logic [2:0] codes [4] = '{`IR_BYPASS, 3'h3, 3'h5, 3'h6};
    foreach (codes[i]) begin
      load_ir(codes[i]);
      u_host.shift(1'b0, 8, 109'hA5, d);
      `CHK("bypass_path", 8'h4A, d[7:0])
    end
    $display("bypass test done");
  endtask
  task automatic t_sample();
    load_ir(`IR_SAMPLE_PRE);
    u_host.shift(1'b0, 109, PRE_A, d);
    `CHK("sample_ring", RING_A, d)
    `CHK("preload", PRE_A, PIN_DRIVE)
    `CHK("sample_sel", 1'b0, PIN_DRIVE_SEL)
    `CHK("sample_bus", 1'b1, OUT_BUS_EN)
    $display("sample test done");
  endtask
  task automatic t_extest();
    load_ir(`IR_EXTEST);
    `CHK("ext_sel", 1'b1, PIN_DRIVE_SEL)
    `CHK("ext_bus_on", 1'b1, OUT_BUS_EN)
    u_host.shift(1'b0, 109, PRE_B, d);
    `CHK("ext_ring", RING_A, d)
    `CHK("ext_drive", PRE_B, PIN_DRIVE)
    `CHK("ext_bus_off", 1'b0, OUT_BUS_EN)
    $display("extest test done");
  endtask
  task automatic t_float();
    load_ir(`IR_SAMPLE_FLOAT);
    `CHK("float_bus", 1'b0, OUT_BUS_EN)
    u_host.shift(1'b0, 109, PRE_A, d);
    `CHK("float_ring", RING_A, d)
    `CHK("float_hold", 1'b0, OUT_BUS_EN)
    load_ir(`IR_BYPASS);
    `CHK("float_end", 1'b1, OUT_BUS_EN)
    @(posedge REF_CLK) #1;
    MEM_OUT_EN = 1'b0;
    repeat (3) @(posedge REF_CLK);
    #1;
    `CHK("mem_follow", 1'b0, OUT_BUS_EN)
    MEM_OUT_EN = 1'b1;
    $display("float test done");
  endtask
  task automatic t_reset();
    load_ir(`IR_EXTEST);
    u_host.shift(1'b0, 109, PRE_A, d);
    `CHK("rst_pre", 1'b1, OUT_BUS_EN)
    u_host.tap_reset();
    u_host.shift(1'b0, 32, 109'h0, d);
    `CHK("rst_id", `ID_CODE, d[31:0])
    load_ir(`IR_EXTEST);
    `CHK("rst_float", 1'b0, OUT_BUS_EN)
    $display("reset test done");
  endtask
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    SYS_RST = 1'b1;
    MEM_OUT_EN = 1'b1;
    PIN_RING = RING_A;
    repeat (2) @(posedge REF_CLK);
    #1;
    SYS_RST = 1'b0;
    repeat (4) @(posedge REF_CLK);
    u_host.tap_reset();
    t_ident();
    t_bypass();
    t_sample();
    t_extest();
    t_float();
    t_reset();
    summarize();
  end
endmodule
